// >>> hdl/led_pwm_engine_ctrl.v
// led pwm source selection, pwm timing and engine execution control
`timescale 1ns/1ps
`include "led_pwm_consts.vh"
module led_pwm_engine_ctrl #(
    parameter ENGINES = 3,
    parameter OUTPUTS = 4
) (
    input  wire                 i_clk,
    input  wire                 i_reset_n,
    input  wire                 i_reg_wr,
    input  wire                 i_reg_rd,
    input  wire [7:0]           i_reg_addr,
    input  wire [7:0]           i_reg_wdata,
    output reg  [7:0]           o_reg_rdata,
    input  wire [8*ENGINES-1:0] i_engine_pwm,
    input  wire [ENGINES-1:0]   i_instr_done,
    output reg  [ENGINES-1:0]   o_instr_start,
    output wire [4*ENGINES-1:0] o_engine_pc,
    output wire [OUTPUTS-1:0]   o_led_pwm,
    output wire [8*OUTPUTS-1:0] o_led_current,
    output wire                 o_chip_enable,
    output wire                 o_int_clk_sel
);
    localparam integer DIV_LF_I  = `PWM_DIV_LF;
    localparam integer DIV_HF_I  = `PWM_DIV_HF;
    localparam integer DIV_ENG_I = `ENGINE_DIV;
    localparam [11:0]  DIV_LF    = DIV_LF_I[11:0];
    localparam [11:0]  DIV_HF    = DIV_HF_I[11:0];
    localparam [11:0]  DIV_ENG   = DIV_ENG_I[11:0];

    // ****************************************************************
    // host registers
    // ****************************************************************
    reg  [1:0]           enable_top_r;
    reg  [7:0]           operation_mode_register_r;
    reg  [7:0]           blue_pwm_r;
    reg  [7:0]           green_pwm_r;
    reg  [7:0]           red_pwm_r;
    reg  [7:0]           white_pwm_r;
    reg  [7:0]           blue_cur_r;
    reg  [7:0]           green_cur_r;
    reg  [7:0]           red_cur_r;
    reg  [7:0]           white_cur_r;
    reg  [7:0]           config_r;
    reg  [7:0]           source_map_r;
    wire [2*ENGINES-1:0] exec_field;
    wire                 log_en;
    wire                 pwm_high_frequency;
    wire                 any_load;

    wire wr_en   = i_reg_wr && (i_reg_addr == `ADDR_ENABLE);

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            enable_top_r <= 2'h0;
            operation_mode_register_r    <= `RST_ZERO;
            blue_pwm_r   <= `RST_ZERO;
            green_pwm_r  <= `RST_ZERO;
            red_pwm_r    <= `RST_ZERO;
            white_pwm_r  <= `RST_ZERO;
            blue_cur_r   <= `RST_CURRENT;
            green_cur_r  <= `RST_CURRENT;
            red_cur_r    <= `RST_CURRENT;
            white_cur_r  <= `RST_CURRENT;
            config_r     <= `RST_ZERO;
            source_map_r <= `RST_ZERO;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `ADDR_ENABLE: begin
                    enable_top_r <= i_reg_wdata[7:6];
                end
                `ADDR_OPERATION_MODE_REGISTER: begin
                    operation_mode_register_r <= {2'h0, i_reg_wdata[5:0]};
                end
                `ADDR_BLUE_PWM: begin
                    blue_pwm_r <= i_reg_wdata;
                end
                `ADDR_GREEN_PWM: begin
                    green_pwm_r <= i_reg_wdata;
                end
                `ADDR_RED_PWM: begin
                    red_pwm_r <= i_reg_wdata;
                end
                `ADDR_WHITE_PWM: begin
                    white_pwm_r <= i_reg_wdata;
                end
                `ADDR_BLUE_CUR: begin
                    blue_cur_r <= i_reg_wdata;
                end
                `ADDR_GREEN_CUR: begin
                    green_cur_r <= i_reg_wdata;
                end
                `ADDR_RED_CUR: begin
                    red_cur_r <= i_reg_wdata;
                end
                `ADDR_WHITE_CUR: begin
                    white_cur_r <= i_reg_wdata;
                end
                `ADDR_CONFIG: begin
                    config_r <= i_reg_wdata;
                end
                `ADDR_SOURCE_MAP: begin
                    source_map_r <= i_reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    assign log_en        = enable_top_r[`EN_LOG_BIT - 6];
    assign o_chip_enable = enable_top_r[`EN_CHIP_BIT - 6];
    assign pwm_high_frequency        = config_r[`CFG_PWM_HIGH_FREQUENCY_BIT];
    assign o_int_clk_sel = config_r[`CFG_INT_CLK_BIT];
    assign o_led_current = {white_cur_r, red_cur_r, green_cur_r, blue_cur_r};

    // ****************************************************************
    // timebases
    // ****************************************************************
    reg  [11:0] pwm_div_r;
    reg  [7:0]  pwm_cnt_r;
    reg  [11:0] eng_div_r;
    reg         eng_tick_r;
    wire [11:0] pwm_div_end;

    assign pwm_div_end = pwm_high_frequency ? (DIV_HF - 12'h001) : (DIV_LF - 12'h001);

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pwm_div_r <= 12'h000;
            pwm_cnt_r <= 8'h00;
        end else if (pwm_div_r >= pwm_div_end) begin
            // >= so a rate switch mid-period cannot overrun the divider
            pwm_div_r <= 12'h000;
            pwm_cnt_r <= pwm_cnt_r + 8'h01;
        end else begin
            pwm_div_r <= pwm_div_r + 12'h001;
        end
    end

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            eng_div_r  <= 12'h000;
            eng_tick_r <= 1'b0;
        end else if (eng_div_r == DIV_ENG - 12'h001) begin
            eng_div_r  <= 12'h000;
            eng_tick_r <= 1'b1;
        end else begin
            eng_div_r  <= eng_div_r + 12'h001;
            eng_tick_r <= 1'b0;
        end
    end

    // ****************************************************************
    // engine execution control
    // ****************************************************************
    wire [7:0] direct_src [0:ENGINES-1];
    wire [7:0] engine_out [0:ENGINES-1];
    wire [3:0] pc_word    [0:ENGINES-1];
    wire [ENGINES-1:0] load_vec;

    assign direct_src[0] = blue_pwm_r;
    assign direct_src[1] = green_pwm_r;
    assign direct_src[2] = red_pwm_r;
    assign any_load = |load_vec;

    genvar e;
    generate
        for (e = 0; e < ENGINES; e = e + 1) begin : g_engine
            localparam LO = 2 * (ENGINES - 1 - e);
            reg  [1:0] exec_r;
            reg  [3:0] pc_r;
            reg        busy_r;
            reg  [7:0] frozen_r;
            wire [1:0] mode = operation_mode_register_r[LO+1:LO];
            localparam integer PC_ADDR = `ADDR_PC_ENG1 + e;
            wire       pc_wr = i_reg_wr && (i_reg_addr == PC_ADDR[7:0]) &&
                               (exec_r == `EXEC_HOLD);
            wire       pc_clr = (mode != `MODE_RUN);
            wire       can_go = (mode == `MODE_RUN) && !any_load &&
                                o_chip_enable;
            wire       start = eng_tick_r && !busy_r && can_go &&
                               (exec_r != `EXEC_HOLD);
            wire       done = busy_r && i_instr_done[e];

            assign load_vec[e] = (mode == `MODE_LOAD);
            assign exec_field[LO+1:LO] = exec_r;
            assign pc_word[e] = pc_r;
            assign o_engine_pc[4*e+3:4*e] = pc_r;

            always @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    exec_r        <= `EXEC_HOLD;
                    pc_r          <= 4'h0;
                    busy_r        <= 1'b0;
                    o_instr_start[e] <= 1'b0;
                end else begin
                    o_instr_start[e] <= start;
                    if (start) begin
                        busy_r <= 1'b1;
                    end else if (done || mode != `MODE_RUN) begin
                        busy_r <= 1'b0;
                    end
                    // host write taken last so a new field is never lost
                    if (done && (exec_r == `EXEC_STEP ||
                                 exec_r == `EXEC_SINGLE)) begin
                        exec_r <= `EXEC_HOLD;
                    end
                    if (wr_en) begin
                        exec_r <= i_reg_wdata[LO+1:LO];
                    end
                    if (pc_clr) begin
                        pc_r <= 4'h0;
                    end else if (pc_wr) begin
                        pc_r <= i_reg_wdata[3:0];
                    end else if (done && exec_r != `EXEC_SINGLE) begin
                        // wraps from the last slot back to slot zero
                        pc_r <= (pc_r == `PC_LAST) ? 4'h0 :
                                pc_r + 4'h1;
                    end
                end
            end

            // engine values freeze while any engine is loading
            always @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    frozen_r <= 8'h00;
                end else if (!any_load) begin
                    frozen_r <= i_engine_pwm[8*e+7:8*e];
                end
            end

            assign engine_out[e] =
                (mode == `MODE_DIRECT)   ? direct_src[e] :
                (mode == `MODE_DISABLED) ? 8'h00 :
                frozen_r;
        end
    endgenerate

    // ****************************************************************
    // output source selection and waveform
    // ****************************************************************
    wire [7:0] host_pwm [0:OUTPUTS-1];

    assign host_pwm[0] = blue_pwm_r;
    assign host_pwm[1] = green_pwm_r;
    assign host_pwm[2] = red_pwm_r;
    assign host_pwm[3] = white_pwm_r;

    genvar c;
    generate
        for (c = 0; c < OUTPUTS; c = c + 1) begin : g_output
            wire [1:0] sel = source_map_r[2*c+1:2*c];
            reg  [7:0] duty;
            wire       wave;

            // no staging register: a host write reaches the compare at once
            always @* begin
                case (sel)
                    2'h1: duty = engine_out[0];
                    2'h2: duty = engine_out[1];
                    2'h3: duty = engine_out[2];
                    default: duty = host_pwm[c];
                endcase
            end

            pwm_compare u_compare (
                .i_clk     (i_clk),
                .i_reset_n (i_reset_n),
                .i_duty    (duty),
                .i_log_en  (log_en),
                .i_count   (pwm_cnt_r),
                .o_pwm     (wave)
            );

            assign o_led_pwm[c] = wave && o_chip_enable;
        end
    endgenerate

    // ****************************************************************
    // read path
    // ****************************************************************
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `ADDR_ENABLE:     o_reg_rdata <= {enable_top_r, exec_field};
                `ADDR_OPERATION_MODE_REGISTER:    o_reg_rdata <= operation_mode_register_r;
                `ADDR_BLUE_PWM:   o_reg_rdata <= blue_pwm_r;
                `ADDR_GREEN_PWM:  o_reg_rdata <= green_pwm_r;
                `ADDR_RED_PWM:    o_reg_rdata <= red_pwm_r;
                `ADDR_WHITE_PWM:  o_reg_rdata <= white_pwm_r;
                `ADDR_BLUE_CUR:   o_reg_rdata <= blue_cur_r;
                `ADDR_GREEN_CUR:  o_reg_rdata <= green_cur_r;
                `ADDR_RED_CUR:    o_reg_rdata <= red_cur_r;
                `ADDR_WHITE_CUR:  o_reg_rdata <= white_cur_r;
                `ADDR_CONFIG:     o_reg_rdata <= config_r;
                `ADDR_SOURCE_MAP: o_reg_rdata <= source_map_r;
                // pc reads back only while the engine is held
                `ADDR_PC_ENG1: begin
                    if (exec_field[5:4] == `EXEC_HOLD) begin
                        o_reg_rdata <= {4'h0, pc_word[0]};
                    end else begin
                        o_reg_rdata <= 8'h00;
                    end
                end
                `ADDR_PC_ENG2: begin
                    if (exec_field[3:2] == `EXEC_HOLD) begin
                        o_reg_rdata <= {4'h0, pc_word[1]};
                    end else begin
                        o_reg_rdata <= 8'h00;
                    end
                end
                `ADDR_PC_ENG3: begin
                    if (exec_field[1:0] == `EXEC_HOLD) begin
                        o_reg_rdata <= {4'h0, pc_word[2]};
                    end else begin
                        o_reg_rdata <= 8'h00;
                    end
                end
                default:          o_reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule // led_pwm_engine_ctrl

// >>> hdl/led_pwm_consts.vh
// constants for the led pwm source and engine execution block
`ifndef LED_PWM_CONSTS_VH
`define LED_PWM_CONSTS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_ENABLE        8'h00
`define ADDR_OPERATION_MODE_REGISTER       8'h01
`define ADDR_BLUE_PWM      8'h02
`define ADDR_GREEN_PWM     8'h03
`define ADDR_RED_PWM       8'h04
`define ADDR_BLUE_CUR      8'h05
`define ADDR_GREEN_CUR     8'h06
`define ADDR_WHITE_CUR     8'h07
`define ADDR_CONFIG        8'h08
`define ADDR_PC_ENG1       8'h09
`define ADDR_PC_ENG2       8'h0A
`define ADDR_PC_ENG3       8'h0B
`define ADDR_WHITE_PWM     8'h0E
`define ADDR_RED_CUR       8'h0F
`define ADDR_SOURCE_MAP    8'h70

// ****************************************************************
// field positions
// ****************************************************************
`define EN_LOG_BIT         7
`define EN_CHIP_BIT        6
`define CFG_PWM_HIGH_FREQUENCY_BIT     6
`define CFG_INT_CLK_BIT    0

// ****************************************************************
// field codes
// ****************************************************************
`define EXEC_HOLD          2'h0
`define EXEC_STEP          2'h1
`define EXEC_RUN           2'h2
`define EXEC_SINGLE        2'h3
`define MODE_DISABLED      2'h0
`define MODE_LOAD          2'h1
`define MODE_RUN           2'h2
`define MODE_DIRECT        2'h3
`define SEL_HOST           2'h0

// ****************************************************************
// reset values and last pc slot
// ****************************************************************
`define RST_CURRENT        8'hAF
`define RST_ZERO           8'h00
`define PC_LAST            4'hF

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ             125000000
`define PWM_LF_HZ          256
`define PWM_HIGH_FREQUENCY_HZ          558
`define PWM_STEPS          256
`define ENGINE_CLK_HZ      32768
`define PWM_DIV_LF         (`CLK_HZ / (`PWM_LF_HZ * `PWM_STEPS))
`define PWM_DIV_HF         (`CLK_HZ / (`PWM_HIGH_FREQUENCY_HZ * `PWM_STEPS))
`define ENGINE_DIV         (`CLK_HZ / `ENGINE_CLK_HZ)

`endif

// >>> hdl/pwm_compare.v
// duty scaling and waveform compare for one led output
`timescale 1ns/1ps
module pwm_compare (
    input  wire       i_clk,
    input  wire       i_reset_n,
    input  wire [7:0] i_duty,
    input  wire       i_log_en,
    input  wire [7:0] i_count,
    output reg        o_pwm
);
    wire [15:0] square;
    wire [7:0]  scaled;

    // ****************************************************************
    // scaling
    // ****************************************************************
    // square law stands in for the eye-linear curve; cheap, monotonic
    assign square = i_duty * i_duty;
    assign scaled = i_log_en ? square[15:8] : i_duty;

    // ****************************************************************
    // compare
    // ****************************************************************
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pwm <= 1'b0;
        end else begin
            // full code forced high so 0xFF is a true 100 percent
            o_pwm <= (i_duty == 8'hFF) || (i_count < scaled);
        end
    end
endmodule // pwm_compare

// >>> tb/led_pwm_checker_assertions.sv
// assertion checker bound to the led pwm engine control block
`timescale 1ns/1ps
module led_pwm_checker #(
    parameter ENGINES = 3,
    parameter OUTPUTS = 4
) (
    input wire                 i_clk,
    input wire                 i_reset_n,
    input wire                 i_reg_wr,
    input wire                 i_reg_rd,
    input wire [7:0]           i_reg_addr,
    input wire [7:0]           i_reg_wdata,
    input wire [7:0]           o_reg_rdata,
    input wire [ENGINES-1:0]   i_instr_done,
    input wire [ENGINES-1:0]   o_instr_start,
    input wire [4*ENGINES-1:0] o_engine_pc,
    input wire [OUTPUTS-1:0]   o_led_pwm,
    input wire [8*OUTPUTS-1:0] o_led_current,
    input wire                 o_chip_enable,
    input wire                 o_int_clk_sel
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    reg  mode_wr_d;
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) mode_wr_d <= 1'b0;
        else mode_wr_d <= i_reg_wr && (i_reg_addr == 8'h01);
    end
    // pc writes load at once; a mode write clears pc one cycle later
    wire pc_wr = (i_reg_wr && i_reg_addr == 8'h09) || mode_wr_d;
    wire wd_b6 = i_reg_wdata[6];
    wire wd_b0 = i_reg_wdata[0];
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ****************************************************************
    // assertions
    // ****************************************************************
    cur_reset_a: assert property ($rose(i_reset_n) |->
        o_led_current == 32'hAFAFAFAF) else $error("current not default");
    cur_write_a: assert property (i_reg_wr && i_reg_addr == 8'h05 |=>
        o_led_current[7:0] == $past(i_reg_wdata)) else $error("current lost");
    chip_en_a: assert property (i_reg_wr && i_reg_addr == 8'h00 |=>
        o_chip_enable == $past(wd_b6)) else $error("chip enable wrong");
    int_clk_a: assert property (i_reg_wr && i_reg_addr == 8'h08 |=>
        o_int_clk_sel == $past(wd_b0)) else $error("clock select wrong");
    pwm_gate_a: assert property (!o_chip_enable |->
        o_led_pwm == 4'h0) else $error("output on while disabled");
    rdata_hold_a: assert property (!i_reg_rd |=>
        $stable(o_reg_rdata)) else $error("read data moved");
    pc_hold_a: assert property (!i_instr_done[0] && !pc_wr |=>
        $stable(o_engine_pc[3:0])) else $error("pc moved without done");
    pc_step_a: assert property ($changed(o_engine_pc[3:0]) &&
        o_engine_pc[3:0] != 4'h0 && !$past(pc_wr) |->
        o_engine_pc[3:0] == $past(o_engine_pc[3:0]) + 4'h1)
        else $error("pc step not one");
    start_gap_a: assert property (o_instr_start[0] |=>
        !o_instr_start[0] [*8]) else $error("starts too close");
    cover property (o_instr_start[0]);
    cover property ($changed(o_engine_pc[3:0]));
    cover property ($rose(o_chip_enable));
endmodule // led_pwm_checker

bind led_pwm_engine_ctrl led_pwm_checker #(.ENGINES(ENGINES),
    .OUTPUTS(OUTPUTS)) u_led_pwm_checker (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_instr_done(i_instr_done),
    .o_instr_start(o_instr_start), .o_engine_pc(o_engine_pc),
    .o_led_pwm(o_led_pwm), .o_led_current(o_led_current),
    .o_chip_enable(o_chip_enable), .o_int_clk_sel(o_int_clk_sel));

// >>> tb/led_host_model.sv
// host model writing and reading the led block registers
`timescale 1ns/1ps
module led_host_model #(
    // waits shortened from the real start-up and enable spacing times
    parameter PWRUP_WAIT = 40,
    parameter START_WAIT = 40,
    parameter EN_GAP     = 4000
) (
    input  wire       i_clk,
    input  wire       i_reset_n,
    input  wire [7:0] i_rdata,
    output reg        o_wr,
    output reg        o_rd,
    output reg  [7:0] o_addr,
    output reg  [7:0] o_wdata
);
    integer cyc     = 0;
    integer last_en = -100000;
    initial begin
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    always @(posedge i_clk) cyc <= cyc + 1;
    // a device reset drops its execution sync, so no spacing is owed
    always @(negedge i_reset_n) last_en = -100000;
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_addr  = a;
        o_wdata = d;
        o_wr    = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
        if (a == 8'h00) last_en = cyc;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_rd   = 1'b1;
        @(posedge i_clk);
        #1;
        o_rd   = 1'b0;
        o_addr = ~a;
        d      = i_rdata;
    endtask
    task wr_en(input logic [7:0] d);
        while (cyc - last_en <= EN_GAP) @(posedge i_clk);
        wr(8'h00, d);
    endtask
    task start_up;
        repeat (PWRUP_WAIT) @(posedge i_clk);
        wr_en(8'h40);
        repeat (START_WAIT) @(posedge i_clk);
        wr(8'h08, 8'h01);
    endtask
endmodule // led_host_model

// >>> tb/led_pwm_source_and_engine_exec_bench.sv
// self-checking bench for the led pwm source and engine control block
`timescale 1ns/1ps
`include "led_pwm_consts.vh"
`define CHECK(g, e) \
    begin \
        num_checks = num_checks + 1; \
        if ((g) !== (e)) begin \
            num_errors = num_errors + 1; \
            $display("wrong value at %0t: got %h want %h", $time, g, e); \
        end \
    end
module led_pwm_source_and_engine_exec_bench;
    reg         clk        = 1'b0;
    reg         reset_n    = 1'b0;
    reg  [23:0] eng_pwm    = 24'h000000;
    reg  [2:0]  instr_done = 3'h0;
    reg  [2:0]  start_d1   = 3'h0;
    reg  [2:0]  start_d2   = 3'h0;
    wire        reg_wr;
    wire        reg_rd;
    wire [7:0]  reg_addr;
    wire [7:0]  reg_wdata;
    wire [7:0]  reg_rdata;
    wire [2:0]  instr_start;
    wire [11:0] engine_pc;
    wire [3:0]  led_pwm;
    wire [31:0] led_current;
    wire        chip_enable;
    wire        int_clk_sel;
    integer     num_errors = 0;
    integer     num_checks = 0;
    integer     n;
    time        t_rel;
    reg  [7:0]  d;
    reg  [3:0]  p;
    always #4 clk = ~clk;
    // instruction unit stand-in: each instruction takes three cycles
    always @(posedge clk) begin
        start_d1   <= instr_start;
        start_d2   <= start_d1;
        instr_done <= start_d2;
    end
    led_pwm_engine_ctrl u_led_pwm_engine_ctrl (.i_clk(clk),
        .i_reset_n(reset_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(reg_rdata), .i_engine_pwm(eng_pwm),
        .i_instr_done(instr_done), .o_instr_start(instr_start),
        .o_engine_pc(engine_pc), .o_led_pwm(led_pwm),
        .o_led_current(led_current), .o_chip_enable(chip_enable),
        .o_int_clk_sel(int_clk_sel));
    led_host_model u_led_host_model (.i_clk(clk), .i_reset_n(reset_n),
        .i_rdata(reg_rdata), .o_wr(reg_wr), .o_rd(reg_rd),
        .o_addr(reg_addr), .o_wdata(reg_wdata));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task wr(input logic [7:0] a, input logic [7:0] v);
        u_led_host_model.wr(a, v);
    endtask
    task rd(input logic [7:0] a);
        u_led_host_model.rd(a, d);
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task do_reset;
        @(posedge clk);
        #1;
        reset_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_rel   = $time;
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task wait_pc(input logic [3:0] v);
        n = 0;
        while (engine_pc[3:0] !== v && n < 12000) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        `CHECK(engine_pc[3:0], v)
        if (n >= 12000) stop_test;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task test_reset;
        do_reset;
        `CHECK(led_current, 32'hAFAFAFAF)
        rd(8'h05);
        `CHECK(d, 8'hAF)
        rd(8'h55);
        `CHECK(d, 8'h00)
        wr(8'h05, 8'h64);
        `CHECK(led_current[7:0], 8'h64)
    endtask
    // counter sits at zero early after reset, so codes near zero show
    task test_scale(input logic log_on, input logic [3:0] exp);
        do_reset;
        wr(8'h70, 8'h00);
        wr(8'h02, 8'h0F);
        wr(8'h03, 8'hFF);
        wr(8'h04, 8'h00);
        wr(8'h0E, 8'h10);
        settle;
        `CHECK(led_pwm, 4'h0)
        if (log_on) u_led_host_model.wr_en(8'hC0);
        else u_led_host_model.start_up;
        settle;
        `CHECK(led_pwm, exp)
    endtask
    task test_freq(input logic [7:0] cfg, input integer div);
        do_reset;
        wr(8'h70, 8'h00);
        wr(8'h02, 8'h01);
        u_led_host_model.start_up;
        wr(8'h08, cfg);
        settle;
        n = 0;
        while (led_pwm[0] !== 1'b0 && n < 3000) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        if (n >= 3000) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: pwm edge timed out", $time);
            stop_test;
        end
        n = ($time - t_rel) / 8;
        `CHECK((n >= div - 30) && (n <= div + 30), 1'b1)
    endtask
    task test_map;
        do_reset;
        u_led_host_model.start_up;
        wr(8'h70, 8'hE4);
        wr(8'h01, 8'h3F);
        wr(8'h02, 8'hFF);
        wr(8'h03, 8'h00);
        wr(8'h04, 8'hFF);
        wr(8'h0E, 8'h00);
        settle;
        `CHECK(led_pwm, 4'hB)
        wr(8'h02, 8'h00);
        settle;
        `CHECK(led_pwm, 4'h8)
        rd(8'h70);
        `CHECK(d, 8'hE4)
        wr(8'h01, 8'hFF);
        rd(8'h01);
        `CHECK(d, 8'h3F)
    endtask
    task test_engine;
        do_reset;
        u_led_host_model.start_up;
        wr(8'h70, 8'h01);
        eng_pwm = 24'hFFFFFF;
        settle;
        `CHECK(led_pwm, 4'h0)
        wr(8'h01, 8'h20);
        settle;
        `CHECK(led_pwm, 4'h1)
        eng_pwm = 24'h000000;
        settle;
        `CHECK(led_pwm, 4'h0)
        wr(8'h09, 8'h05);
        rd(8'h09);
        `CHECK(d, 8'h05)
        u_led_host_model.wr_en(8'h50);
        wait_pc(4'h6);
        rd(8'h00);
        `CHECK(d, 8'h40)
        u_led_host_model.wr_en(8'h70);
        repeat (8000) @(posedge clk);
        #1;
        `CHECK(engine_pc[3:0], 4'h6)
        rd(8'h00);
        `CHECK(d, 8'h40)
        u_led_host_model.wr_en(8'h60);
        wait_pc(4'h8);
        rd(8'h09);
        `CHECK(d, 8'h00)
        u_led_host_model.wr_en(8'h40);
        repeat (10) @(posedge clk);
        #1;
        p = engine_pc[3:0];
        repeat (8000) @(posedge clk);
        #1;
        `CHECK(engine_pc[3:0], p)
        wr(8'h01, 8'h00);
        settle;
        `CHECK(engine_pc[3:0], 4'h0)
    endtask
    initial begin
        test_reset;
        test_scale(1'b0, 4'hB);
        test_scale(1'b1, 4'hA);
        test_freq(8'h41, `PWM_DIV_HF);
        test_freq(8'h01, `PWM_DIV_LF);
        test_map;
        test_engine;
        stop_test;
    end
endmodule // led_pwm_source_and_engine_exec_bench
